// ### logic/sfrb_bank.sv
`timescale 1ns/1ns
`default_nettype none
// Function
// - registers hold last written value until changed
// - unmapped locations read zero, ignore writes
// - unimplemented bits inside registers read zero
// - power resets load first set, others second
// - master clear and watchdog load second set
// - pc latch feeds upper program counter bits
module sfrb_bank (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic [7:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  power_on_reset,
  input  wire logic                  brownout_reset,
  input  wire logic                  master_clear_pin,
  input  wire logic                  watchdog_reset,
  input  wire logic [7:0]            hw_status_set,
  input  wire logic [7:0]            hw_periph_flags_set,
  output logic      [4:0]            pc_upper_bits,
  output logic                       pc_upper_load,
  output logic      [7:0]            port_a_latch,
  output logic      [7:0]            adc_control_out
);
  import sfrb_pkg::*;

  // synchronised reset sources (all arrive from pins or other domains)
  logic [3:0]  rsrc_sync;
  logic        any_power;
  logic        any_other;
  sfrb_rkind_t rkind;

  sfrb_sync #(.WIDTH(4)) u_rsync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({watchdog_reset, master_clear_pin, brownout_reset, power_on_reset}),
    .sync_out (rsrc_sync)
  );

  // power-up kinds win over the others when both come together
  always_comb begin
    any_power = rsrc_sync[0] | rsrc_sync[1];
    any_other = rsrc_sync[2] | rsrc_sync[3];
    if (any_power) begin
      rkind = SFRB_RK_POWER;
    end else if (any_other) begin
      rkind = SFRB_RK_OTHER;
    end else begin
      rkind = SFRB_RK_NONE;
    end
  end

  // bus side decode
  sfrb_req_t   req;
  logic        in_bank;
  logic        implemented;
  logic [7:0]  mask;
  logic        soft_rst_cmd;

  always_comb begin
    req.read  = avs_read;
    req.write = avs_write & avs_byteenable[0];
    req.index = avs_address[5:0];
    req.wdata = avs_writedata[7:0];
  end

  // per-index implemented-bit mask; zero mask means unmapped
  always_comb begin
    in_bank = (avs_address[7:5] == 3'b000);
    mask    = 8'h00;
    if (in_bank) begin
      unique case (req.index[4:0])
        SFRB_IDX_INDIRECT_PORT, SFRB_IDX_TIMER0, SFRB_IDX_PC_LOW,
        SFRB_IDX_STATUS, SFRB_IDX_POINTER, SFRB_IDX_PORT_B, SFRB_IDX_PORT_C,
        SFRB_IDX_INT_CTRL, SFRB_IDX_TIMER1_LOW, SFRB_IDX_TIMER1_HIGH,
        SFRB_IDX_TIMER2, SFRB_IDX_SERIAL_BUF, SFRB_IDX_SERIAL_CTRL,
        SFRB_IDX_CCP_LOW, SFRB_IDX_CCP_HIGH, SFRB_IDX_ADC_RESULT:
          mask = SFRB_MASK_FULL;
        SFRB_IDX_PORT_A:      mask = SFRB_MASK_PORT_A;
        SFRB_IDX_PC_LATCH:    mask = SFRB_MASK_PC_LATCH;
        SFRB_IDX_PERIPH_FLAGS: mask = SFRB_MASK_PERIPH;
        SFRB_IDX_TIMER1_CTRL: mask = SFRB_MASK_TIMER1_CTL;
        SFRB_IDX_TIMER2_CTRL: mask = SFRB_MASK_TIMER2_CTL;
        SFRB_IDX_CCP_CTRL:    mask = SFRB_MASK_CCP_CTL;
        SFRB_IDX_ADC_CTRL:    mask = SFRB_MASK_ADC_CTL;
        default:              mask = 8'h00;
      endcase
    end
    implemented  = (mask != 8'h00);
  end

  // bus slave handshake: write completes after one wait cycle, read waits one more for storage
  sfrb_state_t st_r;
  sfrb_state_t st_nxt;
  logic        wr_ack;

  always_comb begin
    st_nxt       = st_r;
    wr_ack       = 1'b0;
    soft_rst_cmd = 1'b0;
    unique case (st_r)
      SFRB_ST_IDLE: begin
        if (avs_read) begin
          st_nxt = SFRB_ST_READ;
        end else if (avs_write) begin
          st_nxt = SFRB_ST_DONE;
        end
      end
      SFRB_ST_READ: st_nxt = SFRB_ST_DONE;
      SFRB_ST_DONE: begin
        st_nxt       = SFRB_ST_IDLE;
        // a write lands only at the edge that samples waitrequest low
        wr_ack       = avs_write;
        soft_rst_cmd = req.write && (avs_address == {2'b00, SFRB_IDX_SOFT_RESET});
      end
      default:      st_nxt = SFRB_ST_IDLE;
    endcase
  end

  // storage: every bank byte register lives in static storage; the reset cause word is in flip-flops
  logic        init_busy_r;      // walks the array after a reset
  logic        init_busy_nxt;
  logic [4:0]  init_idx_r;
  logic [4:0]  init_idx_nxt;
  sfrb_rkind_t init_kind_r;
  sfrb_rkind_t init_kind_nxt;
  logic        st_we;
  logic [4:0]  st_waddr;
  logic [7:0]  st_wdata;
  logic [4:0]  st_raddr;
  logic [7:0]  st_rdata;
  logic [7:0]  init_val;
  logic        init_hit;
  logic [7:0]  rst_cause_r;
  logic [7:0]  rst_cause_nxt;

  sfrb_store #(.DEPTH(32), .AW(5)) u_store (
    .ref_clk (ref_clk),
    .we      (st_we),
    .waddr   (st_waddr),
    .wdata   (st_wdata),
    .raddr   (st_raddr),
    .rdata   (st_rdata)
  );

  // value for one location during the reset walk; other resets keep most contents
  always_comb begin
    init_hit = 1'b1;
    init_val = SFRB_RST_ZERO;
    unique case (init_idx_r)
      SFRB_IDX_INDIRECT_PORT, SFRB_IDX_PC_LOW, SFRB_IDX_PC_LATCH,
      SFRB_IDX_PERIPH_FLAGS, SFRB_IDX_TIMER2, SFRB_IDX_TIMER2_CTRL,
      SFRB_IDX_SERIAL_CTRL, SFRB_IDX_CCP_CTRL, SFRB_IDX_ADC_CTRL:
        init_val = SFRB_RST_ZERO;                      // same in both sets
      SFRB_IDX_STATUS: begin
        init_val = SFRB_RST_STATUS_POR;
        if (init_kind_r == SFRB_RK_OTHER) begin
          // q bits follow the condition; kept low bits come from the stored value
          init_val = (st_rdata & SFRB_STATUS_KEEP) | (hw_status_set & SFRB_STATUS_COND);
        end
      end
      SFRB_IDX_PORT_A:
        init_val = (init_kind_r == SFRB_RK_OTHER) ? (st_rdata & SFRB_PORT_A_KEEP)
                                                  : SFRB_RST_ZERO;
      SFRB_IDX_INT_CTRL:
        init_val = (init_kind_r == SFRB_RK_OTHER) ? (st_rdata & SFRB_INT_CTRL_KEEP)
                                                  : SFRB_RST_ZERO;
      SFRB_IDX_TIMER1_CTRL:
        init_hit = (init_kind_r != SFRB_RK_OTHER);     // unchanged on other resets
      default:
        init_hit = (init_kind_r != SFRB_RK_OTHER);     // unknown -> zero, or kept
    endcase
  end

  // port arbitration: reset walk reads then writes each location in two steps
  logic        walk_phase_r;
  logic        walk_phase_nxt;
  logic [7:0]  wr_val;

  always_comb begin
    wr_val   = (req.wdata & mask) | (hw_periph_flags_set & SFRB_MASK_PERIPH
               & {8{req.index[4:0] == SFRB_IDX_PERIPH_FLAGS}});   // set wins
    st_raddr = init_busy_r ? init_idx_r : req.index[4:0];
    st_we    = 1'b0;
    st_waddr = req.index[4:0];
    st_wdata = wr_val;
    if (init_busy_r) begin
      st_we    = walk_phase_r & init_hit;
      st_waddr = init_idx_r;
      st_wdata = init_val & SFRB_MASK_FULL;
    end else if (wr_ack && req.write && implemented) begin
      st_we = 1'b1;
    end
  end

  // walk sequencing after any reset request
  always_comb begin
    init_busy_nxt  = init_busy_r;
    init_idx_nxt   = init_idx_r;
    init_kind_nxt  = init_kind_r;
    walk_phase_nxt = walk_phase_r;
    rst_cause_nxt  = rst_cause_r;
    if (rkind != SFRB_RK_NONE || soft_rst_cmd) begin
      init_busy_nxt  = 1'b1;
      init_idx_nxt   = 5'h00;
      walk_phase_nxt = 1'b0;
      init_kind_nxt  = (rkind == SFRB_RK_POWER) ? SFRB_RK_POWER : SFRB_RK_OTHER;
      rst_cause_nxt  = {4'h0, rsrc_sync[3], rsrc_sync[2] | soft_rst_cmd,
                        rsrc_sync[1], rsrc_sync[0]};
    end else if (init_busy_r) begin
      walk_phase_nxt = ~walk_phase_r;
      if (walk_phase_r) begin
        init_idx_nxt = 5'(init_idx_r + 5'h01);
        if (init_idx_r == 5'h1f) begin
          init_busy_nxt = 1'b0;
        end
      end
    end
  end

  // read data path and outputs, all from flip-flops
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        wait_r;
  logic        wait_nxt;
  logic        rd_mapped_r;
  logic [7:0]  rd_mask_r;
  logic [5:0]  rd_index_r;
  logic [4:0]  pcu_r;
  logic [4:0]  pcu_nxt;
  logic        pcl_r;
  logic        pcl_nxt;
  logic [7:0]  pa_r;
  logic [7:0]  pa_nxt;
  logic [7:0]  adc_r;
  logic [7:0]  adc_nxt;

  always_comb begin
    rdata_nxt = rdata_r;
    // waitrequest drops for exactly the completion cycle of an access
    wait_nxt  = ~((st_nxt == SFRB_ST_DONE) && !init_busy_r);
    if (st_r == SFRB_ST_READ) begin
      if (rd_index_r == SFRB_IDX_RESET_CAUSE) begin
        rdata_nxt = {24'h000000, rst_cause_r};
      end else if (rd_mapped_r) begin
        rdata_nxt = {24'h000000, st_rdata & rd_mask_r};
      end else begin
        rdata_nxt = 32'h00000000;
      end
    end
    pcu_nxt = pcu_r;
    pcl_nxt = 1'b0;
    pa_nxt  = pa_r;
    adc_nxt = adc_r;
    if (init_busy_r && walk_phase_r && init_hit) begin
      if (init_idx_r == SFRB_IDX_PC_LATCH)  pcu_nxt = init_val[4:0];
      if (init_idx_r == SFRB_IDX_PORT_A)    pa_nxt  = init_val & SFRB_MASK_PORT_A;
      if (init_idx_r == SFRB_IDX_ADC_CTRL)  adc_nxt = init_val & SFRB_MASK_ADC_CTL;
    end else if (st_we && !init_busy_r) begin
      if (st_waddr == SFRB_IDX_PC_LATCH)    pcu_nxt = st_wdata[4:0];
      if (st_waddr == SFRB_IDX_PC_LOW)      pcl_nxt = 1'b1;
      if (st_waddr == SFRB_IDX_PORT_A)      pa_nxt  = st_wdata;
      if (st_waddr == SFRB_IDX_ADC_CTRL)    adc_nxt = st_wdata;
    end
  end

  // register everything; the storage array itself carries no reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r         <= SFRB_ST_IDLE;
      init_busy_r  <= 1'b1;
      init_idx_r   <= 5'h00;
      init_kind_r  <= SFRB_RK_POWER;
      walk_phase_r <= 1'b0;
      rst_cause_r  <= 8'h01;
      rdata_r      <= 32'h00000000;
      wait_r       <= 1'b1;
      rd_mapped_r  <= 1'b0;
      rd_mask_r    <= 8'h00;
      rd_index_r   <= 6'h00;
      pcu_r        <= 5'h00;
      pcl_r        <= 1'b0;
      pa_r         <= 8'h00;
      adc_r        <= 8'h00;
    end else begin
      // the bus holds off while the reset walk runs
      st_r         <= init_busy_r ? SFRB_ST_IDLE : st_nxt;
      init_busy_r  <= init_busy_nxt;
      init_idx_r   <= init_idx_nxt;
      init_kind_r  <= init_kind_nxt;
      walk_phase_r <= walk_phase_nxt;
      rst_cause_r  <= rst_cause_nxt;
      rdata_r      <= rdata_nxt;
      wait_r       <= wait_nxt;
      if (st_r == SFRB_ST_IDLE) begin
        rd_mapped_r <= implemented;
        rd_mask_r   <= mask;
        rd_index_r  <= (avs_address[7:6] != 2'b00) ? 6'h3f : avs_address[5:0];
      end
      pcu_r        <= pcu_nxt;
      pcl_r        <= pcl_nxt;
      pa_r         <= pa_nxt;
      adc_r        <= adc_nxt;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign pc_upper_bits   = pcu_r;
  assign pc_upper_load   = pcl_r;
  assign port_a_latch    = pa_r;
  assign adc_control_out = adc_r;
endmodule
`default_nettype wire

// ### include/sfrb_pkg.sv
`default_nettype none
// shared constants and carriers for the bank 0 register map
package sfrb_pkg;

  // register offsets (printed offsets are not all multiples of four: these are indices)
  localparam logic [4:0] SFRB_IDX_INDIRECT_PORT = 5'h00;
  localparam logic [4:0] SFRB_IDX_TIMER0        = 5'h01;
  localparam logic [4:0] SFRB_IDX_PC_LOW        = 5'h02;
  localparam logic [4:0] SFRB_IDX_STATUS        = 5'h03;
  localparam logic [4:0] SFRB_IDX_POINTER       = 5'h04;
  localparam logic [4:0] SFRB_IDX_PORT_A        = 5'h05;
  localparam logic [4:0] SFRB_IDX_PORT_B        = 5'h06;
  localparam logic [4:0] SFRB_IDX_PORT_C        = 5'h07;
  localparam logic [4:0] SFRB_IDX_PC_LATCH      = 5'h0a;
  localparam logic [4:0] SFRB_IDX_INT_CTRL      = 5'h0b;
  localparam logic [4:0] SFRB_IDX_PERIPH_FLAGS  = 5'h0c;
  localparam logic [4:0] SFRB_IDX_TIMER1_LOW    = 5'h0e;
  localparam logic [4:0] SFRB_IDX_TIMER1_HIGH   = 5'h0f;
  localparam logic [4:0] SFRB_IDX_TIMER1_CTRL   = 5'h10;
  localparam logic [4:0] SFRB_IDX_TIMER2        = 5'h11;
  localparam logic [4:0] SFRB_IDX_TIMER2_CTRL   = 5'h12;
  localparam logic [4:0] SFRB_IDX_SERIAL_BUF    = 5'h13;
  localparam logic [4:0] SFRB_IDX_SERIAL_CTRL   = 5'h14;
  localparam logic [4:0] SFRB_IDX_CCP_LOW       = 5'h15;
  localparam logic [4:0] SFRB_IDX_CCP_HIGH      = 5'h16;
  localparam logic [4:0] SFRB_IDX_CCP_CTRL      = 5'h17;
  localparam logic [4:0] SFRB_IDX_ADC_RESULT    = 5'h1e;
  localparam logic [4:0] SFRB_IDX_ADC_CTRL      = 5'h1f;
  // control and status words of our own, in a gap of the printed bank or beyond it
  localparam logic [4:0] SFRB_IDX_PC_HIGH_VIEW  = 5'h18; // unused slot, kept zero
  localparam logic [5:0] SFRB_IDX_RESET_CAUSE   = 6'h20; // reset cause word
  localparam logic [5:0] SFRB_IDX_SOFT_RESET    = 6'h21; // soft reset command word

  // implemented-bit masks
  localparam logic [7:0] SFRB_MASK_FULL       = 8'hff;
  localparam logic [7:0] SFRB_MASK_PORT_A     = 8'h3f;
  localparam logic [7:0] SFRB_MASK_PC_LATCH   = 8'h1f;
  localparam logic [7:0] SFRB_MASK_PERIPH     = 8'h4f;
  localparam logic [7:0] SFRB_MASK_TIMER1_CTL = 8'h3f;
  localparam logic [7:0] SFRB_MASK_TIMER2_CTL = 8'h7f;
  localparam logic [7:0] SFRB_MASK_CCP_CTL    = 8'h3f;
  localparam logic [7:0] SFRB_MASK_ADC_CTL    = 8'hfd;

  // power-up reset values (unknown bits taken as zero)
  localparam logic [7:0] SFRB_RST_ZERO        = 8'h00;
  localparam logic [7:0] SFRB_RST_STATUS_POR  = 8'h18;
  // status bits on other resets: top three clear, bits 4:3 by condition, low three kept
  localparam logic [7:0] SFRB_STATUS_KEEP     = 8'h07;
  localparam logic [7:0] SFRB_STATUS_COND     = 8'h18;
  // port a: bit 4 kept on other resets, the rest cleared
  localparam logic [7:0] SFRB_PORT_A_KEEP     = 8'h10;
  // interrupt control: bit 0 kept on other resets
  localparam logic [7:0] SFRB_INT_CTRL_KEEP   = 8'h01;

  // reset cause word field positions
  localparam int SFRB_CAUSE_POR_BIT  = 0;
  localparam int SFRB_CAUSE_BOR_BIT  = 1;
  localparam int SFRB_CAUSE_MASTER_CLEAR_PIN_BIT = 2;
  localparam int SFRB_CAUSE_WDT_BIT  = 3;

  // bus request carrier
  typedef struct packed {
    logic       read;
    logic       write;
    logic [5:0] index;
    logic [7:0] wdata;
  } sfrb_req_t;

  // reset kinds
  typedef enum logic [1:0] {
    SFRB_RK_NONE  = 2'b00,
    SFRB_RK_POWER = 2'b01,
    SFRB_RK_OTHER = 2'b10
  } sfrb_rkind_t;

  // bus slave states
  typedef enum logic [1:0] {
    SFRB_ST_IDLE  = 2'b00,
    SFRB_ST_READ  = 2'b01,
    SFRB_ST_DONE  = 2'b10
  } sfrb_state_t;

endpackage
`default_nettype wire

// ### logic/sfrb_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two flip-flop synchroniser for WIDTH pin-side levels
module sfrb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;   // first stage, read only by the second
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] hold_r;   // second stage, safe to use
  logic [WIDTH-1:0] hold_nxt;

  // refuse an empty synchroniser at elaboration
  if (WIDTH < 1) begin : g_bad_width
    $error("sfrb_sync width must be at least one");
  end

  // next values: plain shift
  always_comb begin
    meta_nxt = async_in;
    hold_nxt = meta_r;
  end

  // register both stages
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= '0;
      hold_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign sync_out = hold_r;
endmodule
`default_nettype wire

// ### logic/sfrb_store.sv
`timescale 1ns/1ns
`default_nettype none
// small static storage array with registered read data
module sfrb_store #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic          ref_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem_r [DEPTH];  // contents, no reset: values stand until rewritten
  logic [7:0] rdata_r;        // registered read port

  // refuse a depth that the address cannot reach, at elaboration
  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("sfrb_store depth exceeds address range");
  end

  // write and read, both on the clock; read data lag the address by one edge
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
    rdata_r <= mem_r[raddr];
  end

  assign rdata = rdata_r;
endmodule
`default_nettype wire

// ### tb/sfrb_bank_checker.sv
`timescale 1ns/1ns
`default_nettype none
// port-level watcher for the bank 0 register map
module sfrb_bank_checker (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [4:0]  pc_upper_bits,
  input wire logic        pc_upper_load,
  input wire logic [7:0]  port_a_latch,
  input wire logic [7:0]  adc_control_out
);
  // reset forces the bus quiet; no disable here on purpose
  AST_RST_WAIT: assert property (@(posedge ref_clk) rst |=> avs_waitrequest)
    else $error("waitrequest low right after reset");
  AST_RST_RDATA: assert property (@(posedge ref_clk) rst |=> avs_readdata == 32'h0)
    else $error("read data not cleared by reset");
  // an answer is a one-cycle pulse tied to a request
  AST_ACK_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest) else $error("answer longer than one cycle");
  AST_ACK_CAUSE: assert property (@(posedge ref_clk) disable iff (rst)
    !avs_waitrequest |-> avs_read || avs_write) else $error("answer with no request");
  // a read is never answered at the edge that first sees it
  AST_READ_LAT: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(avs_read) |-> avs_waitrequest) else $error("read answered too early");
  // only the low byte carries data; unimplemented port a and adc control bits stay low
  AST_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    avs_readdata[31:8] == 24'h0) else $error("upper read data bits set");
  AST_PORT_A_DATA_BITS: assert property (@(posedge ref_clk) disable iff (rst)
    port_a_latch[7:6] == 2'b00) else $error("port a top bits set");
  AST_ADC_BIT1: assert property (@(posedge ref_clk) disable iff (rst)
    adc_control_out[1] == 1'b0) else $error("adc control bit 1 set");
  // counter reload pulse follows an accepted write to the low counter byte
  AST_PC_LOAD: assert property (@(posedge ref_clk) disable iff (rst)
    avs_write && !avs_waitrequest && avs_address == 8'h02 && avs_byteenable[0]
    |=> pc_upper_load ##1 !pc_upper_load) else $error("reload pulse missing");
  // the upper bits move only after a latch write, or back to zero on reset
  AST_PC_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(pc_upper_bits) && !$past(rst) |-> pc_upper_bits == 5'h00
    || $past(avs_write && avs_address == 8'h0a, 1)
    || $past(avs_write && avs_address == 8'h0a, 2)) else $error("latch changed alone");
endmodule
bind sfrb_bank sfrb_bank_checker u_chk (
  .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pc_upper_bits(pc_upper_bits),
  .pc_upper_load(pc_upper_load), .port_a_latch(port_a_latch),
  .adc_control_out(adc_control_out)
);
`default_nettype wire

// ### tb/tb_sfrb_bank.sv
`timescale 1ns/1ns
`default_nettype none
// directed bench for the bank 0 register map
module tb_sfrb_bank;
  import sfrb_pkg::*;
  logic        ref_clk;
  logic        rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  rsrc;          // power, brownout, master clear, watchdog
  logic [7:0]  periph_set;    // hardware flag sets into the peripheral flags
  logic [4:0]  pc_upper_bits;
  logic        pc_upper_load;
  logic [7:0]  port_a_latch;
  logic [7:0]  adc_control_out;
  int          err_count;
  int          samples_checked;
  int          cycles;
  sfrb_bank u_dut (
    .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .power_on_reset(rsrc[0]), .brownout_reset(rsrc[1]), .master_clear_pin(rsrc[2]),
    .watchdog_reset(rsrc[3]), .hw_status_set(8'h10), .hw_periph_flags_set(periph_set),
    .pc_upper_bits(pc_upper_bits), .pc_upper_load(pc_upper_load),
    .port_a_latch(port_a_latch), .adc_control_out(adc_control_out)
  );
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard, well above the fewer than two thousand cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until waitrequest is sampled low, then one idle edge
  task automatic bus_write(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
    avs_address    <= idx;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic read_check(input logic [7:0] idx, input logic [7:0] exp);
    avs_address <= idx;
    avs_read    <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    check(avs_readdata, {24'h0, exp});
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  // implemented bits per location; unmapped ones hold nothing
  function automatic logic [7:0] mask_of(input logic [7:0] i);
    case (i)
      8'h05, 8'h10, 8'h17:                      mask_of = 8'h3f;
      8'h0a:                                    mask_of = 8'h1f;
      8'h0c:                                    mask_of = 8'h4f;
      8'h12:                                    mask_of = 8'h7f;
      8'h1f:                                    mask_of = 8'hfd;
      8'h08, 8'h09, 8'h0d, 8'h18, 8'h19, 8'h1a,
      8'h1b, 8'h1c, 8'h1d:                      mask_of = 8'h00;
      default:                                  mask_of = 8'hff;
    endcase
  endfunction
  // value after a reset when every location from 1 up but status first held all ones
  function automatic logic [7:0] after_reset(input logic [7:0] i, input logic pwr);
    case (i)
      8'h03:                         after_reset = pwr ? 8'h18 : 8'h10;
      8'h02, 8'h0a, 8'h0c, 8'h11,
      8'h12, 8'h14, 8'h17, 8'h1f:    after_reset = 8'h00;
      8'h05:                         after_reset = pwr ? 8'h00 : 8'h10;
      8'h0b:                         after_reset = pwr ? 8'h00 : 8'h01;
      default:                       after_reset = pwr ? 8'h00 : mask_of(i);
    endcase
  endfunction
  task automatic fill_ones();
    for (int i = 1; i < 32; i++) begin
      if (i != 3) bus_write(i[7:0], 8'hff, 4'hf);
    end
  endtask
  initial begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    rsrc = 4'h0;
    periph_set = 8'h00;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // bus reset acts as power-up: first value set
    for (int i = 1; i < 32; i++) read_check(i[7:0], after_reset(i[7:0], 1'b1));
    read_check(8'h20, 8'h01);
    $display("test power set done");
    // every location from 1 up but status retains its implemented bits; gaps stay zero
    fill_ones();
    for (int i = 1; i < 32; i++) begin
      if (i != 3) read_check(i[7:0], mask_of(i[7:0]));
    end
    bus_write(8'h01, 8'h00, 4'h0);
    read_check(8'h01, 8'hff);
    $display("test retention done");
    // latch feeds the upper counter bits, reload pulse on low byte write
    bus_write(8'h0a, 8'hf5, 4'hf);
    @(posedge ref_clk);
    check({27'h0, pc_upper_bits}, 32'h15);
    bus_write(8'h02, 8'h33, 4'hf);
    check({24'h0, port_a_latch}, 32'h3f);
    check({24'h0, adc_control_out}, 32'hfd);
    // soft reset loads the second set: kept bytes stay, latch clears
    bus_write(8'h21, 8'h00, 4'hf);
    read_check(8'h20, 8'h04);
    read_check(8'h01, 8'hff);
    read_check(8'h0a, 8'h00);
    check({27'h0, pc_upper_bits}, 32'h00);
    // hardware flag set wins over the written value, gaps stay zero
    periph_set <= 8'hff;
    bus_write(8'h0c, 8'h00, 4'hf);
    periph_set <= 8'h00;
    read_check(8'h0c, 8'h4f);
    $display("test counter latch done");
    // each reset source, then the set it must load
    for (int s = 0; s < 4; s++) begin
      fill_ones();
      rsrc[s] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rsrc[s] <= 1'b0;
      repeat (4) @(posedge ref_clk);
      for (int i = 1; i < 32; i++) read_check(i[7:0], after_reset(i[7:0], s < 2));
      read_check(8'h20, 8'(1 << s));
      $display("test reset source %0d done", s);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
